// >>> src/lpsd_pkg.sv
// Constants, types and helper functions of the SDRAM pin interface.
package lpsd_pkg;

	// Command codes as {chip_select_n, row_strobe_n, column_strobe_n,
	// write_strobe_n}; a set top bit means deselected.
	localparam logic [3:0] CMD_LMR      = 4'h0;
	localparam logic [3:0] CMD_REF      = 4'h1;
	localparam logic [3:0] CMD_PRE      = 4'h2;
	localparam logic [3:0] CMD_ACT      = 4'h3;
	localparam logic [3:0] CMD_WR       = 4'h4;
	localparam logic [3:0] CMD_RD       = 4'h5;
	localparam logic [3:0] CMD_BST      = 4'h6;
	localparam logic [3:0] CMD_NOP      = 4'h7;
	localparam logic [3:0] CMD_DESELECT = 4'hf;

	// Mode register layout and reset value.
	localparam int          MODE_W      = 14;
	localparam int          MODE_BL_LSB = 0;
	localparam int          MODE_BT_BIT = 3;
	localparam logic [13:0] MODE_RESET  = 14'h0000;
	localparam int          AP_BIT      = 10;

	// Burst length codes and the full-page length.
	localparam logic [2:0] BL_1    = 3'h0;
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [9:0] PAGE_LEN = 10'h200;

	// Power states, one-hot.
	typedef enum logic [4:0] {
		ST_RUN  = 5'h01,
		ST_SUSP = 5'h02,
		ST_PDA  = 5'h04,
		ST_PDP  = 5'h08,
		ST_SREF = 5'h10
	} lpsd_pstate_t;

	function automatic logic [9:0] lpsd_burst_len(input logic [2:0] code);
		case (code)
			BL_1:    lpsd_burst_len = 10'h001;
			BL_2:    lpsd_burst_len = 10'h002;
			BL_4:    lpsd_burst_len = 10'h004;
			BL_8:    lpsd_burst_len = 10'h008;
			BL_PAGE: lpsd_burst_len = PAGE_LEN;
			default: lpsd_burst_len = 10'h001;
		endcase
	endfunction

	// Column of burst step idx; wraps inside the block of len columns.
	function automatic logic [8:0] lpsd_burst_col(input logic [8:0] start,
			input logic [9:0] idx, input logic [9:0] len, input logic inter);
		logic [8:0] m;
		logic [8:0] off;
		m = 9'(len - 10'h001);
		off = (inter && len != PAGE_LEN) ? (start ^ idx[8:0])
			: 9'(start + idx[8:0]);
		lpsd_burst_col = (start & ~m) | (off & m);
	endfunction

endpackage

// >>> src/lpsd_pin_if.sv
// Command and data pin interface of a four-bank 16-bit low-power SDRAM.
// Summary of operation
// - All pins registered on rising clock only.
// - Burst counter and core read/write strobes advance on enabled clocks.
// - Clock gate low: power-down, self refresh, suspend.
// - Low-power states ignore pins, gate watched through a two-flop synchroniser.
// - Deselected cycles decode no command.
// - Command from four strobes on one edge.
// - Masked write lanes leave memory unchanged.
// - Read mask floats lane two clocks later.
// - Lower mask bits 0-7, upper 8-15.
// - Bank select steers command to one bank.
// - Activate captures twelve-bit row address.
// - Read/write column from bits 0-8, auto precharge for bursts of 2, 4, 8.
// - Precharge all or selected bank by flag.
// - Load mode takes opcode from address and bank.
// - Burst lengths 1, 2, 4, 8, full page.
// - Mode bits 0-2 length, bit 3 order.
`timescale 1ns/1ps
`default_nettype none
module lpsd_pin_if
	import lpsd_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         reset,
	input  wire logic         clk_gate_in,
	input  wire logic         chip_select_n,
	input  wire logic         row_strobe_n,
	input  wire logic         column_strobe_n,
	input  wire logic         write_strobe_n,
	input  wire logic [1:0]   bank_select,
	input  wire logic [11:0]  address_inputs,
	input  wire logic         lower_byte_mask,
	input  wire logic         upper_byte_mask,
	input  wire logic [15:0]  dq_in,
	output logic      [15:0]  dq_out,
	output logic      [1:0]   dq_oe,
	output logic              core_wr_en,
	output logic              core_rd_en,
	output logic      [1:0]   core_byte_en,
	output logic      [1:0]   core_bank,
	output logic      [11:0]  core_row,
	output logic      [8:0]   core_col,
	output logic      [15:0]  core_wdata,
	input  wire logic [15:0]  core_rdata,
	output logic              core_refresh,
	output logic      [13:0]  mode_reg,
	output lpsd_pstate_t      power_state
);

	logic [3:0]   s_cmd_reg;
	logic [1:0]   s_ba_reg;
	logic [11:0]  s_addr_reg;
	logic [1:0]   s_mask_reg;
	logic [15:0]  s_dq_reg;
	logic         s_cke_reg;
	logic         cke_meta_reg;
	logic         cke_sync_reg;
	lpsd_pstate_t state_reg;
	logic [3:0]   row_open_reg;
	logic [11:0]  open_row_reg [4];
	logic         burst_act_reg;
	logic         burst_wr_reg;
	logic         burst_ap_reg;
	logic [1:0]   burst_bank_reg;
	logic [8:0]   burst_start_reg;
	logic [9:0]   burst_idx_reg;
	logic         rd_pend_reg;
	logic [1:0]   mask_d_reg;
	logic         low_power;
	logic         en;
	logic         new_rw;
	logic         cont;
	logic         burst_last;
	logic [9:0]   blen;
	logic [9:0]   idx_next;

	assign low_power = (state_reg == ST_PDA) || (state_reg == ST_PDP)
		|| (state_reg == ST_SREF);
	assign en = (state_reg == ST_RUN) && s_cke_reg;
	assign blen = lpsd_burst_len(mode_reg[MODE_BL_LSB +: 3]);
	assign new_rw = en && (s_cmd_reg == CMD_RD || s_cmd_reg == CMD_WR);
	assign cont = en && burst_act_reg && !new_rw && s_cmd_reg != CMD_BST;
	assign idx_next = burst_idx_reg + 10'h001;
	assign burst_last = cont && idx_next == blen && blen != PAGE_LEN;

	// The gate is resynchronised for wake-up from low-power states.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cke_meta_reg <= 1'b0;
			cke_sync_reg <= 1'b0;
		end else begin
			cke_meta_reg <= clk_gate_in;
			cke_sync_reg <= cke_meta_reg;
		end
	end

	// Pin sampling; input buffers are off in power-down and self refresh.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s_cmd_reg  <= CMD_DESELECT;
			s_ba_reg   <= 2'h0;
			s_addr_reg <= 12'h000;
			s_mask_reg <= 2'h0;
			s_dq_reg   <= 16'h0000;
			// Starts high so that leaving reset does not look like a gate drop.
			s_cke_reg  <= 1'b1;
		end else if (low_power) begin
			s_cmd_reg <= CMD_DESELECT;
			s_cke_reg <= cke_sync_reg;
		end else begin
			s_cmd_reg  <= {chip_select_n, row_strobe_n,
				column_strobe_n, write_strobe_n};
			s_ba_reg   <= bank_select;
			s_addr_reg <= address_inputs;
			s_mask_reg <= {upper_byte_mask, lower_byte_mask};
			s_dq_reg   <= dq_in;
			s_cke_reg  <= clk_gate_in;
		end
	end

	// Power state follows the registered clock gate.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_RUN;
		end else begin
			case (state_reg)
				ST_RUN: begin
					if (!s_cke_reg) begin
						if (burst_act_reg) begin
							state_reg <= ST_SUSP;
						end else if (s_cmd_reg == CMD_REF) begin
							state_reg <= ST_SREF;
						end else if (|row_open_reg) begin
							state_reg <= ST_PDA;
						end else begin
							state_reg <= ST_PDP;
						end
					end
				end
				default: begin
					if (s_cke_reg) begin
						state_reg <= ST_RUN;
					end
				end
			endcase
		end
	end

	// Mode register load.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			mode_reg <= MODE_RESET;
		end else if (en && s_cmd_reg == CMD_LMR) begin
			mode_reg <= {s_ba_reg, s_addr_reg};
		end
	end

	// Open rows per bank.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			row_open_reg <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				open_row_reg[i] <= 12'h000;
			end
		end else if (en) begin
			if (s_cmd_reg == CMD_ACT) begin
				row_open_reg[s_ba_reg] <= 1'b1;
				open_row_reg[s_ba_reg] <= s_addr_reg;
			end else if (s_cmd_reg == CMD_PRE) begin
				if (s_addr_reg[AP_BIT]) begin
					row_open_reg <= 4'h0;
				end else begin
					row_open_reg[s_ba_reg] <= 1'b0;
				end
			end else if (burst_last && burst_ap_reg) begin
				row_open_reg[burst_bank_reg] <= 1'b0;
			end
		end
	end

	// Burst counter; it holds while the clock is suspended.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			burst_act_reg   <= 1'b0;
			burst_wr_reg    <= 1'b0;
			burst_ap_reg    <= 1'b0;
			burst_bank_reg  <= 2'h0;
			burst_start_reg <= 9'h000;
			burst_idx_reg   <= 10'h000;
		end else if (new_rw) begin
			burst_act_reg   <= blen != 10'h001;
			burst_wr_reg    <= s_cmd_reg == CMD_WR;
			burst_ap_reg    <= s_addr_reg[AP_BIT];
			burst_bank_reg  <= s_ba_reg;
			burst_start_reg <= s_addr_reg[8:0];
			burst_idx_reg   <= 10'h001;
		end else if (en && burst_act_reg) begin
			if (s_cmd_reg == CMD_BST || burst_last) begin
				burst_act_reg <= 1'b0;
			end
			burst_idx_reg <= (idx_next == PAGE_LEN) ? 10'h000
				: idx_next;
		end
	end

	// Array access towards the core, one location per enabled clock.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			core_wr_en   <= 1'b0;
			core_rd_en   <= 1'b0;
			core_byte_en <= 2'h0;
			core_bank    <= 2'h0;
			core_row     <= 12'h000;
			core_col     <= 9'h000;
			core_wdata   <= 16'h0000;
			core_refresh <= 1'b0;
		end else begin
			core_refresh <= en && s_cmd_reg == CMD_REF;
			core_wr_en <= (new_rw && s_cmd_reg == CMD_WR)
				|| (cont && burst_wr_reg);
			core_rd_en <= (new_rw && s_cmd_reg == CMD_RD)
				|| (cont && !burst_wr_reg);
			core_byte_en <= ~s_mask_reg;
			core_wdata <= s_dq_reg;
			if (new_rw) begin
				core_bank <= s_ba_reg;
				core_row  <= open_row_reg[s_ba_reg];
				core_col  <= lpsd_burst_col(s_addr_reg[8:0], 10'h000,
					blen, mode_reg[MODE_BT_BIT]);
			end else if (cont) begin
				core_col <= lpsd_burst_col(burst_start_reg, burst_idx_reg,
					blen, mode_reg[MODE_BT_BIT]);
			end
		end
	end

	// Read data out; the mask reaches the drivers two clocks late.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rd_pend_reg <= 1'b0;
			mask_d_reg  <= 2'h0;
			dq_out      <= 16'h0000;
			dq_oe       <= 2'h0;
		end else begin
			rd_pend_reg <= core_rd_en;
			mask_d_reg  <= s_mask_reg;
			if (rd_pend_reg) begin
				dq_out <= core_rdata;
				dq_oe  <= ~mask_d_reg;
			end else begin
				dq_oe  <= 2'h0;
			end
		end
	end

	assign power_state = state_reg;

	default clocking dflt_cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	cs_masked_a: assert property (
		(s_cmd_reg[3] && !burst_act_reg && en)
			|=> !core_wr_en && !core_rd_en && !core_refresh)
		else $error("deselected cycle caused an access");
	act_row_a: assert property (
		(en && s_cmd_reg == CMD_ACT) |=> row_open_reg[$past(s_ba_reg)]
			&& open_row_reg[$past(s_ba_reg)] == $past(s_addr_reg))
		else $error("activate did not capture the row");
	rd_mask_lat_a: assert property (
		(s_mask_reg[0] ##1 rd_pend_reg) |=> !dq_oe[0])
		else $error("read mask did not float lower lane");
	wr_lanes_a: assert property (
		core_wr_en |-> core_byte_en == ~$past(s_mask_reg))
		else $error("write lane enable does not follow mask");
	pre_all_a: assert property (
		(en && s_cmd_reg == CMD_PRE && s_addr_reg[AP_BIT])
			|=> row_open_reg == 4'h0)
		else $error("precharge all left a row open");
	lmr_code_a: assert property (
		(en && s_cmd_reg == CMD_LMR)
			|=> mode_reg == $past({s_ba_reg, s_addr_reg}))
		else $error("mode load took wrong opcode");
	suspend_entry_a: assert property (
		(state_reg == ST_RUN && !s_cke_reg && burst_act_reg)
			|=> state_reg == ST_SUSP ##1 $stable(burst_idx_reg))
		else $error("burst not suspended on gate low");
	lp_inputs_off_a: assert property (
		(state_reg == ST_PDP) ##1 (state_reg == ST_PDP)
			|-> s_cmd_reg == CMD_DESELECT)
		else $error("pins sampled during power-down");
	burst_len_a: assert property (
		(new_rw && blen == 10'h004 && !s_cmd_reg[0] && !burst_act_reg
			&& s_cmd_reg == CMD_WR) ##1 (en && s_cmd_reg == CMD_NOP)[*3]
			|=> !burst_act_reg)
		else $error("burst of four did not end");

endmodule // lpsd_pin_if
`default_nettype wire

// >>> sim/lpsd_core_model.sv
// Behavioural model of the memory array behind the pin interface.
`timescale 1ns/1ps
`default_nettype none
module lpsd_core_model (
	input  wire logic        ref_clk,
	input  wire logic        core_wr_en,
	input  wire logic        core_rd_en,
	input  wire logic [1:0]  core_byte_en,
	input  wire logic [1:0]  core_bank,
	input  wire logic [11:0] core_row,
	input  wire logic [8:0]  core_col,
	input  wire logic [15:0] core_wdata,
	output logic      [15:0] core_rdata
);
	logic [15:0] mem [logic [22:0]];
	logic [22:0] key;
	assign key = {core_bank, core_row, core_col};
	initial core_rdata = 16'h5a5a;
	always @(posedge ref_clk) begin
		if (core_wr_en) begin
			if (!mem.exists(key))
				mem[key] = 16'h0000;
			if (core_byte_en[0])
				mem[key][7:0] = core_wdata[7:0];
			if (core_byte_en[1])
				mem[key][15:8] = core_wdata[15:8];
		end
		// Data is valid only in the cycle after a read strobe.
		if (core_rd_en)
			core_rdata <= mem.exists(key) ? mem[key] : 16'h0000;
		else
			core_rdata <= ~core_rdata;
	end
endmodule // lpsd_core_model
`default_nettype wire

// >>> sim/test_lpsd_pin_if.sv
// Self-checking testbench of the SDRAM pin interface.
`timescale 1ns/1ps
`default_nettype none
module test_lpsd_pin_if;
	import lpsd_pkg::*;
	logic ref_clk, reset, clk_gate_in, chip_select_n, row_strobe_n;
	logic column_strobe_n, write_strobe_n, lower_byte_mask;
	logic upper_byte_mask, core_wr_en, core_rd_en, core_refresh;
	logic [1:0] bank_select, dq_oe, core_byte_en, core_bank;
	logic [11:0] address_inputs, core_row, row_v;
	logic [15:0] dq_in, dq_out, core_wdata, core_rdata, d0, d1;
	logic [8:0] core_col;
	logic [13:0] mode_reg;
	lpsd_pstate_t power_state;
	logic [30:0] q[$];
	int bad_count = 0, num_checks = 0, cyc = 0;
	lpsd_pin_if lpsd_pin_if_inst (.ref_clk(ref_clk), .reset(reset),
		.clk_gate_in(clk_gate_in), .chip_select_n(chip_select_n),
		.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
		.write_strobe_n(write_strobe_n), .bank_select(bank_select),
		.address_inputs(address_inputs), .lower_byte_mask(lower_byte_mask),
		.upper_byte_mask(upper_byte_mask), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .core_wr_en(core_wr_en), .core_rd_en(core_rd_en),
		.core_byte_en(core_byte_en), .core_bank(core_bank),
		.core_row(core_row), .core_col(core_col), .core_wdata(core_wdata),
		.core_rdata(core_rdata), .core_refresh(core_refresh),
		.mode_reg(mode_reg), .power_state(power_state));
	lpsd_core_model lpsd_core_model_inst (.ref_clk(ref_clk),
		.core_wr_en(core_wr_en), .core_rd_en(core_rd_en),
		.core_byte_en(core_byte_en), .core_bank(core_bank),
		.core_row(core_row), .core_col(core_col), .core_wdata(core_wdata),
		.core_rdata(core_rdata));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic take(input logic [30:0] got);
		if (q.size() == 0)
			chk(1'b0, "unexpected result");
		else
			chk(q.pop_front() === got, "result mismatch");
	endtask
	task automatic drv(input logic [3:0] c, input logic [1:0] b,
			input logic [11:0] a, input logic [1:0] m, input logic [15:0] d);
		@(negedge ref_clk);
		{chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n} = c;
		bank_select = b;
		address_inputs = a;
		{upper_byte_mask, lower_byte_mask} = m;
		dq_in = d;
	endtask
	// Each result is compared against the oldest noted expectation.
	always begin
		@(posedge ref_clk);
		#1;
		if (core_wr_en === 1'b1) begin
			take({2'd1, core_bank, core_col, core_byte_en, core_wdata &
				{{8{core_byte_en[1]}}, {8{core_byte_en[0]}}}});
			chk(core_row === row_v, "row");
		end
		if (dq_oe !== 2'b00)
			take({2'd2, 11'h0, dq_oe, dq_out &
				{{8{dq_oe[1]}}, {8{dq_oe[0]}}}});
		if (core_refresh === 1'b1)
			take({2'd3, 29'h0});
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			test_done;
		end
	end
	initial begin
		reset = 1'b1;
		clk_gate_in = 1'b1;
		{chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n} = CMD_NOP;
		{bank_select, address_inputs, lower_byte_mask, upper_byte_mask} = '0;
		dq_in = 16'h0000;
		void'($urandom(32'hea97));
		row_v = 12'($urandom);
		d0 = 16'($urandom);
		d1 = 16'($urandom);
		repeat (4) @(negedge ref_clk);
		reset = 1'b0;
		repeat (2) drv(CMD_NOP, 0, 0, 0, 0);
		drv(CMD_PRE, 0, 12'h400, 0, 0);
		repeat (2) begin
			q.push_back({2'd3, 29'h0});
			drv(CMD_REF, 0, 0, 0, 0);
		end
		for (int i = 0; i < 4; i++) begin
			drv(CMD_LMR, 0, 12'(i), 0, 0);
			drv(CMD_ACT, 2, row_v, 0, 0);
			for (int k = 0; k < (1 << i); k++)
				q.push_back({2'd1, 2'd2, 9'(k), 2'b11, d1});
			drv(CMD_WR, 2, 12'h400, 0, d1);
			repeat ((1 << i) + 1) drv(CMD_NOP, 0, 0, 0, d1);
		end
		drv(CMD_LMR, 0, 12'h001, 0, 0);
		repeat (2) drv(CMD_NOP, 0, 0, 0, 0);
		chk(mode_reg === 14'h0001, "mode");
		drv(CMD_ACT, 1, row_v, 0, 0);
		q.push_back({2'd1, 2'd1, 9'h003, 2'b10, d0[15:8], 8'h00});
		q.push_back({2'd1, 2'd1, 9'h002, 2'b11, d1});
		drv(CMD_WR, 1, 12'h003, 2'b01, d0);
		drv(CMD_NOP, 0, 0, 0, d1);
		drv(4'hd, 1, 12'h003, 0, 0);
		q.push_back({2'd2, 11'h0, 2'b10, d0[15:8], 8'h00});
		q.push_back({2'd2, 11'h0, 2'b11, d1});
		drv(CMD_RD, 1, 12'h403, 0, 0);
		drv(CMD_NOP, 0, 0, 2'b01, 0);
		repeat (5) drv(CMD_NOP, 0, 0, 0, 0);
		clk_gate_in = 1'b0;
		drv(CMD_RD, 1, 12'h003, 0, 0);
		repeat (3) drv(CMD_NOP, 0, 0, 0, 0);
		chk(power_state === ST_PDP, "precharge power-down");
		clk_gate_in = 1'b1;
		repeat (6) drv(CMD_NOP, 0, 0, 0, 0);
		chk(power_state === ST_RUN, "wake");
		drv(CMD_ACT, 0, row_v, 0, 0);
		drv(CMD_NOP, 0, 0, 0, 0);
		clk_gate_in = 1'b0;
		repeat (3) drv(CMD_NOP, 0, 0, 0, 0);
		chk(power_state === ST_PDA, "active power-down");
		clk_gate_in = 1'b1;
		repeat (6) drv(CMD_NOP, 0, 0, 0, 0);
		// Clock suspend in the middle of a burst of four.
		drv(CMD_LMR, 0, 12'h002, 0, 0);
		drv(CMD_ACT, 3, row_v, 0, 0);
		for (int k = 0; k < 4; k++)
			q.push_back({2'd1, 2'd3, 9'(k), 2'b11, d1});
		drv(CMD_WR, 3, 12'h000, 0, d1);
		drv(CMD_NOP, 0, 0, 0, d1);
		clk_gate_in = 1'b0;
		repeat (2) drv(CMD_NOP, 0, 0, 0, d1);
		chk(power_state === ST_SUSP, "clock suspend");
		clk_gate_in = 1'b1;
		repeat (5) drv(CMD_NOP, 0, 0, 0, d1);
		// Interleaved burst of four from column 1.
		drv(CMD_LMR, 0, 12'h00a, 0, 0);
		for (int k = 0; k < 4; k++)
			q.push_back({2'd1, 2'd3, 9'(1 ^ k), 2'b11, d0});
		drv(CMD_WR, 3, 12'h001, 0, d0);
		repeat (5) drv(CMD_NOP, 0, 0, 0, d0);
		// Full-page burst cut by burst terminate after two locations.
		drv(CMD_LMR, 0, 12'h007, 0, 0);
		q.push_back({2'd1, 2'd3, 9'h005, 2'b11, d1});
		q.push_back({2'd1, 2'd3, 9'h006, 2'b11, d1});
		drv(CMD_WR, 3, 12'h005, 0, d1);
		drv(CMD_NOP, 0, 0, 0, d1);
		drv(CMD_BST, 0, 0, 0, d1);
		repeat (4) drv(CMD_NOP, 0, 0, 0, d1);
		// Self refresh: refresh command with the gate low, all banks idle.
		drv(CMD_PRE, 0, 12'h400, 0, 0);
		drv(CMD_NOP, 0, 0, 0, 0);
		drv(CMD_REF, 0, 0, 0, 0);
		clk_gate_in = 1'b0;
		repeat (3) drv(CMD_NOP, 0, 0, 0, 0);
		chk(power_state === ST_SREF, "self refresh");
		clk_gate_in = 1'b1;
		repeat (6) drv(CMD_NOP, 0, 0, 0, 0);
		chk(power_state === ST_RUN, "self refresh exit");
		chk(q.size() == 0, "missing results");
		test_done;
	end
endmodule // test_lpsd_pin_if
`default_nettype wire
